/* pkg/pci_pkg.sv */
// constants shared by the pin change interrupt block
// ----------------------------------------------------------------
// How it works
// - enabled summary wakes and interrupts the core
// - edges seen in sleep land in flags first
// - port a rise enables arm rising detection
// - port a fall enables arm falling detection
// - port b rise enables arm rising detection
// - port b fall enables arm falling detection
// - port c rise enables arm rising detection
// - port c fall enables arm falling detection
// - port a flag set only by enabled edge
// - port b flag set only by enabled edge
// - port c flag set only by enabled edge
// - flags sticky; software writes zero to clear
// - every enable and flag resets to zero
// - both enables zero never set flag
// - summary flag is or of all flags
// - detection continues while master enable clear
// - edge during clearing write leaves flag set
// ----------------------------------------------------------------
package pci_pkg;
    localparam int NUM_PORTS = 3;
    localparam int PORT_W = 8;
    // register byte offsets
    localparam logic [7:0] OFF_A_RISE = 8'h00;
    localparam logic [7:0] OFF_A_FALL = 8'h04;
    localparam logic [7:0] OFF_A_FLAGS = 8'h08;
    localparam logic [7:0] OFF_B_RISE = 8'h0c;
    localparam logic [7:0] OFF_B_FALL = 8'h10;
    localparam logic [7:0] OFF_B_FLAGS = 8'h14;
    localparam logic [7:0] OFF_C_RISE = 8'h18;
    localparam logic [7:0] OFF_C_FALL = 8'h1c;
    localparam logic [7:0] OFF_C_FLAGS = 8'h20;
    localparam logic [7:0] OFF_CTRL = 8'h24;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h2c;
    // control register fields
    localparam int CTRL_MASTER_EN_BIT = 0;
    localparam int CTRL_SUMMARY_BIT = 1;
    // irq status fields: one bit per port
    localparam int IRQ_W = 3;
    // reset values
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

/* hdl/pci_top.sv */
// pin change interrupt logic with ahb-lite register slave
`timescale 1ns/100ps
module pci_top #(
    parameter int PORT_W = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [PORT_W-1:0] port_a_pin,
    input wire logic [PORT_W-1:0] port_b_pin,
    input wire logic [PORT_W-1:0] port_c_pin,
    input wire logic sleeping,
    output logic change_irq_summary_flag,
    output logic core_irq,
    output logic wake_up,
    output logic irq
);
    localparam int NP = pci_pkg::NUM_PORTS;

    // ----------------------------------------------------------------
    // ahb-lite address phase capture
    // ----------------------------------------------------------------
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic wr_phase;
    logic rd_take;

    assign ap_valid = hsel && hready && (htrans == pci_pkg::HTRANS_NONSEQ ||
                      htrans == pci_pkg::HTRANS_SEQ);
    assign rd_take = ap_valid && !hwrite;

    // latch address phase for the data phase
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wr_phase <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
        end else begin
            wr_phase <= ap_valid && hwrite;
            ap_write <= ap_valid && hwrite;
            if (ap_valid) begin
                ap_addr <= haddr[7:0];
            end
        end
    end

    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0; // always okay

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [PORT_W-1:0] rise_en [NP];
    logic [PORT_W-1:0] fall_en [NP];
    logic [PORT_W-1:0] flags [NP];
    logic [PORT_W-1:0] pins [NP];
    logic [PORT_W-1:0] edge_set [NP];
    logic [NP-1:0] port_any;
    logic change_irq_master_enable;
    logic [pci_pkg::IRQ_W-1:0] irq_status;
    logic [pci_pkg::IRQ_W-1:0] irq_mask;

    assign pins[0] = port_a_pin;
    assign pins[1] = port_b_pin;
    assign pins[2] = port_c_pin;

    // ----------------------------------------------------------------
    // per-port synchroniser, edge detect and flags
    // ----------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            logic [PORT_W-1:0] sync1;
            logic [PORT_W-1:0] sync2;
            logic [PORT_W-1:0] prev;
            logic [PORT_W-1:0] rising;
            logic [PORT_W-1:0] falling;
            logic wr_rise;
            logic wr_fall;
            logic wr_flags;
            logic [7:0] off_rise;
            logic [7:0] off_fall;
            logic [7:0] off_flags;

            assign off_rise = pci_pkg::OFF_A_RISE + 8'(12 * p);
            assign off_fall = pci_pkg::OFF_A_FALL + 8'(12 * p);
            assign off_flags = pci_pkg::OFF_A_FLAGS + 8'(12 * p);
            assign wr_rise = wr_phase && ap_write && ap_addr == off_rise;
            assign wr_fall = wr_phase && ap_write && ap_addr == off_fall;
            assign wr_flags = wr_phase && ap_write && ap_addr == off_flags;

            // two-stage synchroniser plus previous sample
            always_ff @(posedge clk_sys) begin
                if (!reset_n) begin
                    sync1 <= pci_pkg::PORT_RESET;
                    sync2 <= pci_pkg::PORT_RESET;
                    prev <= pci_pkg::PORT_RESET;
                end else begin
                    sync1 <= pins[p];
                    sync2 <= sync1;
                    prev <= sync2;
                end
            end

            // one-cycle edge pulses gated by the enables
            assign rising = sync2 & ~prev;
            assign falling = ~sync2 & prev;
            assign edge_set[p] = (rising & rise_en[p]) | (falling & fall_en[p]);

            // enable registers
            always_ff @(posedge clk_sys) begin
                if (!reset_n) begin
                    rise_en[p] <= pci_pkg::PORT_RESET;
                    fall_en[p] <= pci_pkg::PORT_RESET;
                end else begin
                    if (wr_rise) begin
                        rise_en[p] <= hwdata[PORT_W-1:0];
                    end
                    if (wr_fall) begin
                        fall_en[p] <= hwdata[PORT_W-1:0];
                    end
                end
            end

            // sticky flags: writes may only clear, a new edge wins
            always_ff @(posedge clk_sys) begin
                if (!reset_n) begin
                    flags[p] <= pci_pkg::PORT_RESET;
                end else if (wr_flags) begin
                    flags[p] <= (flags[p] & hwdata[PORT_W-1:0]) | edge_set[p];
                end else begin
                    flags[p] <= flags[p] | edge_set[p];
                end
            end

            assign port_any[p] = |edge_set[p];
        end
    endgenerate

    // ----------------------------------------------------------------
    // summary, core interrupt and wake
    // ----------------------------------------------------------------
    assign change_irq_summary_flag = |{flags[0], flags[1], flags[2]};
    // request and wake only while master enable set
    assign core_irq = change_irq_summary_flag && change_irq_master_enable;
    assign wake_up = core_irq && sleeping;

    // control and irq mask register write
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            change_irq_master_enable <= 1'b0;
            irq_mask <= pci_pkg::IRQ_RESET;
        end else if (wr_phase && ap_write) begin
            if (ap_addr == pci_pkg::OFF_CTRL) begin
                change_irq_master_enable <= hwdata[pci_pkg::CTRL_MASTER_EN_BIT];
            end
            if (ap_addr == pci_pkg::OFF_IRQ_MASK) begin
                irq_mask <= hwdata[pci_pkg::IRQ_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // bus interrupt status: per-port event, cleared on read
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            irq_status <= pci_pkg::IRQ_RESET;
        end else if (rd_take && haddr[7:0] == pci_pkg::OFF_IRQ_STATUS) begin
            irq_status <= port_any; // set wins over read clear
        end else begin
            irq_status <= irq_status | port_any;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ----------------------------------------------------------------
    // read data, registered in the data phase
    // ----------------------------------------------------------------
    logic [31:0] next_hrdata;

    always_comb begin
        next_hrdata = 32'h0000_0000;
        case (haddr[7:0])
            pci_pkg::OFF_A_RISE: next_hrdata[PORT_W-1:0] = rise_en[0];
            pci_pkg::OFF_A_FALL: next_hrdata[PORT_W-1:0] = fall_en[0];
            pci_pkg::OFF_A_FLAGS: next_hrdata[PORT_W-1:0] = flags[0];
            pci_pkg::OFF_B_RISE: next_hrdata[PORT_W-1:0] = rise_en[1];
            pci_pkg::OFF_B_FALL: next_hrdata[PORT_W-1:0] = fall_en[1];
            pci_pkg::OFF_B_FLAGS: next_hrdata[PORT_W-1:0] = flags[1];
            pci_pkg::OFF_C_RISE: next_hrdata[PORT_W-1:0] = rise_en[2];
            pci_pkg::OFF_C_FALL: next_hrdata[PORT_W-1:0] = fall_en[2];
            pci_pkg::OFF_C_FLAGS: next_hrdata[PORT_W-1:0] = flags[2];
            pci_pkg::OFF_CTRL: begin
                next_hrdata[pci_pkg::CTRL_MASTER_EN_BIT] = change_irq_master_enable;
                next_hrdata[pci_pkg::CTRL_SUMMARY_BIT] = change_irq_summary_flag;
            end
            pci_pkg::OFF_IRQ_STATUS: next_hrdata[pci_pkg::IRQ_W-1:0] = irq_status;
            pci_pkg::OFF_IRQ_MASK: next_hrdata[pci_pkg::IRQ_W-1:0] = irq_mask;
            default: next_hrdata = 32'h0000_0000; // unmapped reads zero
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_take) begin
            hrdata <= next_hrdata;
        end
    end
endmodule

/* testbench/pci_props.sv */
// port-level checker for the pin change interrupt block
`timescale 1ns/100ps
module pci_props #(
    parameter int PORT_W = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [PORT_W-1:0] port_a_pin,
    input wire logic [PORT_W-1:0] port_b_pin,
    input wire logic [PORT_W-1:0] port_c_pin,
    input wire logic sleeping,
    input wire logic change_irq_summary_flag,
    input wire logic core_irq,
    input wire logic wake_up,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // bus transfers taken at an edge
    sequence s_rd;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence s_wr;
        hsel && hready && htrans[1] && hwrite;
    endsequence
    // all pins as one vector
    logic [3*PORT_W-1:0] pins;
    assign pins = {port_a_pin, port_b_pin, port_c_pin};
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    chk_reset_clear: assert property (disable iff (1'b0)
        !reset_n |=> !change_irq_summary_flag && !core_irq && !irq && !wake_up)
        else $error("outputs not cleared by reset");
    chk_core_gate: assert property (core_irq |-> change_irq_summary_flag)
        else $error("core irq without summary flag");
    chk_wake_sleep: assert property (wake_up == (core_irq && sleeping))
        else $error("wake does not follow irq and sleep");
    chk_edge_cause: assert property ($rose(change_irq_summary_flag)
        |-> $past(pins, 3) != $past(pins, 4))
        else $error("summary rose without a pin edge");
    chk_clear_write: assert property ($fell(change_irq_summary_flag)
        |-> !$past(reset_n) || $past(hsel && hready && htrans[1] && hwrite, 2))
        else $error("summary fell without a write");
    chk_unmapped_zero: assert property (s_rd ##0 (haddr[7:0] > 8'h2c) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_upper_zero: assert property (s_rd |=> hrdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    cov_write: cover property (s_wr);
endmodule
bind pci_top pci_props #(.PORT_W(PORT_W)) i_pci_props (.clk_sys(clk_sys), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_a_pin(port_a_pin),
    .port_b_pin(port_b_pin), .port_c_pin(port_c_pin), .sleeping(sleeping),
    .change_irq_summary_flag(change_irq_summary_flag), .core_irq(core_irq),
    .wake_up(wake_up), .irq(irq));

/* testbench/pci_pins.sv */
// model of the port pins and the sleeping core beyond the block
`timescale 1ns/100ps
module pci_pins (
    input wire logic clk_sys,
    input wire logic [23:0] pin_req,
    input wire logic sleep_req,
    input wire logic wake_up,
    output logic [7:0] port_a_pin = 8'h00,
    output logic [7:0] port_b_pin = 8'h00,
    output logic [7:0] port_c_pin = 8'h00,
    output logic sleeping = 1'b0
);
    // pins move just after an edge and hold whole cycles
    always @(posedge clk_sys) begin
        {port_a_pin, port_b_pin, port_c_pin} <= pin_req;
    end
    // core sleeps on request, leaves sleep on wake
    always @(posedge clk_sys) begin
        if (wake_up) begin
            sleeping <= 1'b0;
        end else if (sleep_req) begin
            sleeping <= 1'b1;
        end
    end
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the pin change interrupt block
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_top;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [23:0] pin_req = 24'h0;
    logic sleep_req = 1'b0;
    logic [31:0] hrdata, rd;
    logic [7:0] pa, pb, pc;
    logic hready, hreadyout, hresp, sleeping, summary, core_irq, wake_up, irq;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #50 clk_sys = ~clk_sys;
    assign hready = hreadyout;
    pci_top i_pci_top (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_a_pin(pa),
        .port_b_pin(pb), .port_c_pin(pc), .sleeping(sleeping),
        .change_irq_summary_flag(summary), .core_irq(core_irq), .wake_up(wake_up), .irq(irq));
    pci_pins i_pci_pins (.clk_sys(clk_sys), .pin_req(pin_req), .sleep_req(sleep_req),
        .wake_up(wake_up), .port_a_pin(pa), .port_b_pin(pb), .port_c_pin(pc),
        .sleeping(sleeping));
    // one single bus transfer, read data kept in rd
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= pci_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, rd)
    endtask
    task automatic s_reset_vals;
        for (int a = 0; a <= 'h30; a += 4) begin
            rd_chk(8'(a), 32'h0);
        end
        `CHK("outputs", 3'h0, {summary, core_irq, irq})
    endtask
    task automatic s_edges;
        for (int p = 0; p < 3; p++) begin
            xfer(1'b1, 8'(p * 12), 32'hffffff0f + p);
            xfer(1'b1, 8'(p * 12 + 4), 32'h30 + p);
            rd_chk(8'(p * 12), 32'h0f + p);
            rd_chk(8'(p * 12 + 4), 32'h30 + p);
        end
        pin_req <= 24'hffffff;
        repeat (6) @(posedge clk_sys);
        `CHK("summary", 1'b1, summary)
        `CHK("core irq off", 1'b0, core_irq)
        for (int p = 0; p < 3; p++) begin
            rd_chk(8'(p * 12 + 8), 32'h0f + p);
            xfer(1'b1, 8'(p * 12 + 8), rd & ((32'h0f + p) ^ 32'hff));
            xfer(1'b1, 8'(p * 12 + 8), 32'hff);
            rd_chk(8'(p * 12 + 8), 32'h0);
        end
        `CHK("summary clear", 1'b0, summary)
        xfer(1'b1, pci_pkg::OFF_CTRL, 32'h1);
        sleep_req <= 1'b1;
        @(posedge clk_sys);
        sleep_req <= 1'b0;
        pin_req <= 24'h0;
        repeat (8) @(posedge clk_sys);
        `CHK("woken", 1'b0, sleeping)
        `CHK("core irq", 1'b1, core_irq)
        for (int p = 0; p < 3; p++) begin
            rd_chk(8'(p * 12 + 8), 32'h30 + p);
        end
    endtask
    task automatic s_irq;
        `CHK("irq masked", 1'b0, irq)
        xfer(1'b1, pci_pkg::OFF_IRQ_MASK, 32'h7);
        @(posedge clk_sys);
        `CHK("irq", 1'b1, irq)
        rd_chk(pci_pkg::OFF_IRQ_STATUS, 32'h7);
        rd_chk(pci_pkg::OFF_IRQ_STATUS, 32'h0);
        `CHK("irq cleared", 1'b0, irq)
    endtask
    // edge lands while its flag is being cleared
    task automatic s_race;
        pin_req <= 24'h010000;
        repeat (2) @(posedge clk_sys);
        xfer(1'b1, pci_pkg::OFF_A_FLAGS, 32'h0);
        repeat (2) @(posedge clk_sys);
        rd_chk(pci_pkg::OFF_A_FLAGS, 32'h1);
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            print_verdict;
        end
    end
    // main sequence, with a second reset mid-run
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        s_reset_vals;
        s_edges;
        s_irq;
        s_race;
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        s_reset_vals;
        print_verdict;
    end
endmodule
